// ---- verilog/crf_map.svh ----
// Offsets, flag positions, widths and reset values of the CPU register file
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH

// APB word addresses of the architectural registers
`define CRF_ADR_DR0 8'h00
`define CRF_ADR_DR1 8'h04
`define CRF_ADR_DR2 8'h08
`define CRF_ADR_DR3 8'h0C
`define CRF_ADR_D0L 8'h10
`define CRF_ADR_D0H 8'h14
`define CRF_ADR_D1L 8'h18
`define CRF_ADR_D1H 8'h1C
`define CRF_ADR_P20 8'h20
`define CRF_ADR_P31 8'h24
`define CRF_ADR_AR0 8'h28
`define CRF_ADR_AR1 8'h2C
`define CRF_ADR_A10 8'h30
`define CRF_ADR_FB 8'h34
`define CRF_ADR_PC 8'h38
`define CRF_ADR_VTB 8'h3C
`define CRF_ADR_SP 8'h40
`define CRF_ADR_USP 8'h44
`define CRF_ADR_ISP 8'h48
`define CRF_ADR_SB 8'h4C
`define CRF_ADR_FLG 8'h50

// Flag word bit positions
`define CRF_FLG_C 0
`define CRF_FLG_D 1
`define CRF_FLG_Z 2
`define CRF_FLG_S 3
`define CRF_FLG_B 4
`define CRF_FLG_O 5
`define CRF_FLG_I 6
`define CRF_FLG_U 7
`define CRF_FLG_IPL_LO 12
`define CRF_FLG_IPL_HI 14
// Implemented flag bits; 8..11 and 15 are reserved
`define CRF_FLG_MASK 16'h70FF

// Widths and the software vector limit
`define CRF_AW 20
`define CRF_SWI_USP_LIMIT 6'h20

// Reset values
`define CRF_RST_FLG 16'h0000
`define CRF_RST_PC 20'h00000
`define CRF_RST_W16 16'h0000

`endif

// ---- verilog/crf_pkg.sv ----
// Types of the CPU register file
package crf_pkg;
  `include "crf_map.svh"

  // Register selectors used by the core port and the APB decode
  typedef enum logic [4:0] {
    SEL_DR0, SEL_DR1, SEL_DR2, SEL_DR3,
    SEL_D0L, SEL_D0H, SEL_D1L, SEL_D1H,
    SEL_P20, SEL_P31,
    SEL_AR0, SEL_AR1, SEL_A10,
    SEL_FB, SEL_PC, SEL_VTB,
    SEL_SP, SEL_USP, SEL_ISP, SEL_SB, SEL_FLG
  } crf_sel_t;

  // Whole state of the register file
  typedef struct packed {
    logic [1:0][3:0][15:0] dreg;   // Bank, data register
    logic [1:0][1:0][15:0] areg;   // Bank, address register
    logic [1:0][15:0] fb;          // Banked frame base
    logic [`CRF_AW-1:0] pc;        // Program counter
    logic [`CRF_AW-1:0] vtb;       // Vector table base
    logic [15:0] user_stack_pointer;              // User stack pointer
    logic [15:0] interrupt_stack_pointer;              // Interrupt stack pointer
    logic [15:0] sb;               // Static base
    logic [15:0] flag_word;              // Flag word
    logic sstep;                   // Pending single-step request
    logic [31:0] prdata;           // APB read data
    logic [31:0] rdata;            // Core read data
  } crf_state_t;
endpackage

// ---- verilog/crf_regfile.sv ----
// Programmer-visible CPU register file with flag word and APB access
// How it works
// RL1: Thirteen registers; data, address, frame base banked.
// RL2: Four 16-bit data registers for operands.
// RL3: Data zero/one bytes writable without disturbing.
// RL4: Pairs two-over-zero and three-over-one form 32 bits.
// RL5: Two 16-bit address registers, paired into 32.
// RL6: 16-bit frame base for frame-relative addressing.
// RL7: Program counter is 20 bits wide.
// RL8: Vector table base is 20 bits wide.
// RL9: Flag bit 7 picks user or interrupt stack.
// RL10: Stack select cleared on acknowledge or low software vector.
// RL11: 16-bit static base register.
// RL12: Flag bit 0 captures carry.
// RL13: Debug flag raises single step, cleared on acknowledge.
// RL14: Flag bit 2 marks zero result.
// RL15: Flag bit 3 marks negative result.
// RL16: Flag bit 4 selects register bank.
// RL17: Flag bit 5 marks overflow.
// RL18: Flag bit 6 gates maskable interrupts, cleared on acknowledge.
// RL19: Flag bits 12-14 hold priority level.
// RL20: Accept interrupt only above current priority level.
// RL21: Flag bits 8-11 and 15 reserved.
// RL22: Reserved bits read zero; bank switch copies nothing.
`timescale 1ns/1ps

module crf_regfile
  import crf_pkg::*;
#(
  parameter logic [`CRF_AW-1:0] PC_RESET = `CRF_RST_PC  // Program counter after reset
) (
  input wire logic CLK_I,                 // Core clock
  input wire logic SYS_RST_I,             // Synchronous reset, active high
  input wire logic PSEL_I,                // APB select
  input wire logic PENABLE_I,             // APB enable
  input wire logic PWRITE_I,              // APB direction
  input wire logic [7:0] PADDR_I,         // APB byte address
  input wire logic [31:0] PWDATA_I,       // APB write data
  output logic PREADY_O,                  // APB ready
  output logic [31:0] PRDATA_O,           // APB read data
  output logic PSLVERR_O,                 // APB error on unmapped address
  input wire crf_sel_t RD_SEL_I,          // Core read select
  output logic [31:0] RD_DATA_O,          // Core read data, one cycle later
  input wire logic WR_EN_I,               // Core write strobe
  input wire crf_sel_t WR_SEL_I,          // Core write select
  input wire logic [31:0] WR_DATA_I,      // Core write data
  input wire logic ALU_UPD_I,             // ALU result valid pulse
  input wire logic [15:0] ALU_RES_I,      // ALU result
  input wire logic ALU_C_I,               // ALU carry, borrow or shift-out
  input wire logic ALU_O_I,               // ALU overflow
  input wire logic INSN_DONE_I,           // Instruction completed pulse
  input wire logic IRQ_REQ_I,             // Maskable interrupt requested
  input wire logic [2:0] IRQ_PRIO_I,      // Priority of the request
  output logic IRQ_ACCEPT_O,              // Request may be taken
  input wire logic IRQ_ACK_I,             // Hardware interrupt acknowledged
  input wire logic SWI_I,                 // Software interrupt executed
  input wire logic [5:0] SWI_NUM_I,       // Software interrupt vector number
  output logic SSTEP_REQ_O,               // Single-step interrupt pending
  output logic [`CRF_AW-1:0] PC_O,        // Program counter
  output logic [`CRF_AW-1:0] VTB_O,       // Vector table base
  output logic [15:0] SP_O,               // Active stack pointer
  output logic [15:0] FLAG_O              // Flag word
);

  crf_state_t q;      // Registered state
  crf_state_t d;      // Next state
  crf_sel_t apb_sel;  // Decoded APB register
  logic apb_hit;      // APB address is mapped
  logic apb_wr;       // APB write completes this cycle
  logic apb_setup;    // APB setup phase

  // Read one register as seen through the active bank
  function automatic logic [31:0] rd_fn(crf_state_t s, crf_sel_t sel);
    logic bk;
    logic [31:0] v;
    bk = s.flag_word[`CRF_FLG_B];  // RL1 RL16
    v = 32'h0000_0000;
    case (sel)
      SEL_DR0: v = {16'h0000, s.dreg[bk][0]};  // RL2
      SEL_DR1: v = {16'h0000, s.dreg[bk][1]};
      SEL_DR2: v = {16'h0000, s.dreg[bk][2]};
      SEL_DR3: v = {16'h0000, s.dreg[bk][3]};
      SEL_D0L: v = {24'h000000, s.dreg[bk][0][7:0]};  // RL3
      SEL_D0H: v = {24'h000000, s.dreg[bk][0][15:8]};
      SEL_D1L: v = {24'h000000, s.dreg[bk][1][7:0]};
      SEL_D1H: v = {24'h000000, s.dreg[bk][1][15:8]};
      SEL_P20: v = {s.dreg[bk][2], s.dreg[bk][0]};  // RL4
      SEL_P31: v = {s.dreg[bk][3], s.dreg[bk][1]};
      SEL_AR0: v = {16'h0000, s.areg[bk][0]};  // RL5
      SEL_AR1: v = {16'h0000, s.areg[bk][1]};
      SEL_A10: v = {s.areg[bk][1], s.areg[bk][0]};
      SEL_FB: v = {16'h0000, s.fb[bk]};  // RL6
      SEL_PC: v = {12'h000, s.pc};  // RL7
      SEL_VTB: v = {12'h000, s.vtb};  // RL8
      // Active stack follows the stack select flag
      SEL_SP: v = {16'h0000, s.flag_word[`CRF_FLG_U] ? s.user_stack_pointer : s.interrupt_stack_pointer};  // RL9
      SEL_USP: v = {16'h0000, s.user_stack_pointer};
      SEL_ISP: v = {16'h0000, s.interrupt_stack_pointer};
      SEL_SB: v = {16'h0000, s.sb};  // RL11
      // Reserved flag bits always read as zero
      SEL_FLG: v = {16'h0000, s.flag_word & `CRF_FLG_MASK};  // RL21
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Write one register of the active bank; other bank stays untouched
  function automatic crf_state_t wr_fn(crf_state_t s, crf_sel_t sel, logic [31:0] v);
    crf_state_t n;
    logic bk;
    n = s;
    bk = s.flag_word[`CRF_FLG_B];  // RL1 RL16
    case (sel)
      SEL_DR0: n.dreg[bk][0] = v[15:0];  // RL2
      SEL_DR1: n.dreg[bk][1] = v[15:0];
      SEL_DR2: n.dreg[bk][2] = v[15:0];
      SEL_DR3: n.dreg[bk][3] = v[15:0];
      // Byte writes leave the other half alone
      SEL_D0L: n.dreg[bk][0][7:0] = v[7:0];  // RL3
      SEL_D0H: n.dreg[bk][0][15:8] = v[7:0];  // RL3
      SEL_D1L: n.dreg[bk][1][7:0] = v[7:0];  // RL3
      SEL_D1H: n.dreg[bk][1][15:8] = v[7:0];  // RL3
      // Pairs: upper word goes to the higher register
      SEL_P20: begin  // RL4
        n.dreg[bk][2] = v[31:16];
        n.dreg[bk][0] = v[15:0];
      end
      SEL_P31: begin  // RL4
        n.dreg[bk][3] = v[31:16];
        n.dreg[bk][1] = v[15:0];
      end
      SEL_AR0: n.areg[bk][0] = v[15:0];  // RL5
      SEL_AR1: n.areg[bk][1] = v[15:0];  // RL5
      SEL_A10: begin  // RL5
        n.areg[bk][1] = v[31:16];
        n.areg[bk][0] = v[15:0];
      end
      SEL_FB: n.fb[bk] = v[15:0];  // RL6
      SEL_PC: n.pc = v[`CRF_AW-1:0];  // RL7
      SEL_VTB: n.vtb = v[`CRF_AW-1:0];  // RL8
      // Writing the active stack pointer picks the copy by flag bit 7
      SEL_SP: begin  // RL9
        if (s.flag_word[`CRF_FLG_U]) begin
          n.user_stack_pointer = v[15:0];
        end else begin
          n.interrupt_stack_pointer = v[15:0];
        end
      end
      SEL_USP: n.user_stack_pointer = v[15:0];
      SEL_ISP: n.interrupt_stack_pointer = v[15:0];
      SEL_SB: n.sb = v[15:0];  // RL11
      // Reserved bits ignore writes
      SEL_FLG: n.flag_word = v[15:0] & `CRF_FLG_MASK;  // RL22
      default: n = s;
    endcase
    return n;
  endfunction

  // APB address decode
  always_comb begin
    apb_hit = 1'b1;
    apb_sel = SEL_DR0;
    if (PADDR_I == `CRF_ADR_DR0) begin
      apb_sel = SEL_DR0;
    end else if (PADDR_I == `CRF_ADR_DR1) begin
      apb_sel = SEL_DR1;
    end else if (PADDR_I == `CRF_ADR_DR2) begin
      apb_sel = SEL_DR2;
    end else if (PADDR_I == `CRF_ADR_DR3) begin
      apb_sel = SEL_DR3;
    end else if (PADDR_I == `CRF_ADR_D0L) begin
      apb_sel = SEL_D0L;
    end else if (PADDR_I == `CRF_ADR_D0H) begin
      apb_sel = SEL_D0H;
    end else if (PADDR_I == `CRF_ADR_D1L) begin
      apb_sel = SEL_D1L;
    end else if (PADDR_I == `CRF_ADR_D1H) begin
      apb_sel = SEL_D1H;
    end else if (PADDR_I == `CRF_ADR_P20) begin
      apb_sel = SEL_P20;
    end else if (PADDR_I == `CRF_ADR_P31) begin
      apb_sel = SEL_P31;
    end else if (PADDR_I == `CRF_ADR_AR0) begin
      apb_sel = SEL_AR0;
    end else if (PADDR_I == `CRF_ADR_AR1) begin
      apb_sel = SEL_AR1;
    end else if (PADDR_I == `CRF_ADR_A10) begin
      apb_sel = SEL_A10;
    end else if (PADDR_I == `CRF_ADR_FB) begin
      apb_sel = SEL_FB;
    end else if (PADDR_I == `CRF_ADR_PC) begin
      apb_sel = SEL_PC;
    end else if (PADDR_I == `CRF_ADR_VTB) begin
      apb_sel = SEL_VTB;
    end else if (PADDR_I == `CRF_ADR_SP) begin
      apb_sel = SEL_SP;
    end else if (PADDR_I == `CRF_ADR_USP) begin
      apb_sel = SEL_USP;
    end else if (PADDR_I == `CRF_ADR_ISP) begin
      apb_sel = SEL_ISP;
    end else if (PADDR_I == `CRF_ADR_SB) begin
      apb_sel = SEL_SB;
    end else if (PADDR_I == `CRF_ADR_FLG) begin
      apb_sel = SEL_FLG;
    end else begin
      // Unmapped address
      apb_hit = 1'b0;
    end
  end

  // APB phase decode; the slave always answers in the first access cycle
  always_comb begin
    apb_setup = PSEL_I & ~PENABLE_I;
    apb_wr = PSEL_I & PENABLE_I & PWRITE_I & apb_hit;
  end

  // Next-state logic; later steps take priority over earlier ones
  always_comb begin
    d = q;
    // Read data is captured in the setup phase
    if (apb_setup) begin
      d.prdata = apb_hit ? rd_fn(q, apb_sel) : 32'h0000_0000;
    end
    d.rdata = rd_fn(q, RD_SEL_I);
    // Software write from APB
    if (apb_wr) begin
      d = wr_fn(d, apb_sel, PWDATA_I);
    end
    // Core write wins over APB on the same register
    if (WR_EN_I) begin
      d = wr_fn(d, WR_SEL_I, WR_DATA_I);
    end
    // ALU flag update
    if (ALU_UPD_I) begin
      d.flag_word[`CRF_FLG_C] = ALU_C_I;  // RL12
      d.flag_word[`CRF_FLG_Z] = (ALU_RES_I == 16'h0000);  // RL14
      d.flag_word[`CRF_FLG_S] = ALU_RES_I[15];  // RL15
      d.flag_word[`CRF_FLG_O] = ALU_O_I;  // RL17
    end
    // Acknowledge clears debug, interrupt enable and stack select
    if (IRQ_ACK_I) begin
      d.flag_word[`CRF_FLG_D] = 1'b0;  // RL13
      d.flag_word[`CRF_FLG_I] = 1'b0;  // RL18
      d.flag_word[`CRF_FLG_U] = 1'b0;  // RL10
      d.sstep = 1'b0;  // RL13
    end
    // Software interrupts 0 to 31 move onto the interrupt stack
    if (SWI_I && (SWI_NUM_I < `CRF_SWI_USP_LIMIT)) begin
      d.flag_word[`CRF_FLG_U] = 1'b0;  // RL10
    end
    // Single step pends after each instruction while the debug flag is set; set beats clear
    if (INSN_DONE_I && q.flag_word[`CRF_FLG_D]) begin
      d.sstep = 1'b1;  // RL13
    end
    // Keep reserved bits at zero whatever happened above
    d.flag_word = d.flag_word & `CRF_FLG_MASK;  // RL21
  end

  // State register
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      q <= '0;
      q.pc <= PC_RESET;
      q.flag_word <= `CRF_RST_FLG;
      q.user_stack_pointer <= `CRF_RST_W16;
      q.interrupt_stack_pointer <= `CRF_RST_W16;
    end else begin
      q <= d;
    end
  end

  // Maskable interrupt gate: enable flag and strictly higher priority
  always_comb begin
    IRQ_ACCEPT_O = IRQ_REQ_I & q.flag_word[`CRF_FLG_I]  // RL18
      & (IRQ_PRIO_I > q.flag_word[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO]);  // RL19 RL20
  end

  // Outputs
  always_comb begin
    PREADY_O = PSEL_I & PENABLE_I;
    PSLVERR_O = PSEL_I & PENABLE_I & ~apb_hit;
    PRDATA_O = q.prdata;
    RD_DATA_O = q.rdata;
    SSTEP_REQ_O = q.sstep;
    PC_O = q.pc;
    VTB_O = q.vtb;
    SP_O = q.flag_word[`CRF_FLG_U] ? q.user_stack_pointer : q.interrupt_stack_pointer;  // RL9
    FLAG_O = q.flag_word;
  end

endmodule

// ---- verification/crf_regfile_props.sv ----
// Port assertions for the CPU register file
`timescale 1ns/1ps
module crf_regfile_props (
  input wire logic CLK_I, // Clock
  input wire logic SYS_RST_I, // Reset
  input wire logic ALU_UPD_I, // ALU valid
  input wire logic [15:0] ALU_RES_I, // ALU result
  input wire logic ALU_C_I, // Carry in
  input wire logic ALU_O_I, // Overflow in
  input wire logic INSN_DONE_I, // Instruction retired
  input wire logic IRQ_REQ_I, // Request
  input wire logic [2:0] IRQ_PRIO_I, // Request priority
  input wire logic IRQ_ACCEPT_O, // Accept
  input wire logic IRQ_ACK_I, // Acknowledge
  input wire logic SWI_I, // Software interrupt
  input wire logic [5:0] SWI_NUM_I, // Vector number
  input wire logic SSTEP_REQ_O, // Step pending
  input wire logic [15:0] FLAG_O // Flag word
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  // ALU outcomes land in the flag word one edge later
  a_zero_flag: assert property (
    ALU_UPD_I |=> FLAG_O[2] == ($past(ALU_RES_I) == 16'h0000)) else $error("zero flag wrong");
  a_sign_flag: assert property (
    ALU_UPD_I |=> FLAG_O[3] == $past(ALU_RES_I[15])) else $error("sign flag wrong");
  a_carry_flag: assert property (
    ALU_UPD_I |=> FLAG_O[0] == $past(ALU_C_I)) else $error("carry flag wrong");
  a_ovf_flag: assert property (
    ALU_UPD_I |=> FLAG_O[5] == $past(ALU_O_I)) else $error("overflow flag wrong");
  // Gate needs enable and a strictly higher priority
  a_irq_gate: assert property (
    IRQ_ACCEPT_O == (IRQ_REQ_I && FLAG_O[6] && IRQ_PRIO_I > FLAG_O[14:12]))
    else $error("accept wrong");
  // Acknowledge drops enable, stack select, step
  a_ack_clear: assert property (
    IRQ_ACK_I && !INSN_DONE_I |=> FLAG_O[7:6] == 2'b00 && !FLAG_O[1] && !SSTEP_REQ_O)
    else $error("ack clear wrong");
  a_swi_stack: assert property (
    SWI_I && SWI_NUM_I < 6'h20 |=> !FLAG_O[7]) else $error("swi stack wrong");
  a_step_set: assert property (
    INSN_DONE_I && FLAG_O[1] |=> SSTEP_REQ_O) else $error("step not raised");
  a_resv_zero: assert property (
    (FLAG_O & 16'h8F00) == 16'h0000) else $error("reserved bit set");
endmodule

bind crf_regfile crf_regfile_props u_props (.*);

// ---- verification/crf_core_model.sv ----
// Behavioural decoder and datapath driving the core side
`timescale 1ns/1ps
module crf_core_model
  import crf_pkg::*;
(
  input wire logic CLK_I, // Core clock
  input wire logic [31:0] RD_DATA_O, // Read data back
  output crf_sel_t RD_SEL_I, // Read select
  output logic WR_EN_I, // Write strobe
  output crf_sel_t WR_SEL_I, // Write select
  output logic [31:0] WR_DATA_I, // Write data
  output logic ALU_UPD_I, // ALU valid
  output logic [15:0] ALU_RES_I, // ALU result
  output logic ALU_C_I, // Carry
  output logic ALU_O_I, // Overflow
  output logic INSN_DONE_I, // Retired pulse
  output logic IRQ_REQ_I, // Request
  output logic [2:0] IRQ_PRIO_I, // Priority
  output logic IRQ_ACK_I, // Acknowledge
  output logic SWI_I, // Software interrupt
  output logic [5:0] SWI_NUM_I // Vector number
);
  // Idle at time zero
  initial begin
    RD_SEL_I = SEL_DR0;
    WR_SEL_I = SEL_DR0;
    {WR_EN_I, WR_DATA_I, ALU_UPD_I, ALU_RES_I, ALU_C_I, ALU_O_I, INSN_DONE_I} = '0;
    {IRQ_REQ_I, IRQ_PRIO_I, IRQ_ACK_I, SWI_I, SWI_NUM_I} = '0;
  end
  // Released data lines flip so stale values never pass
  task automatic alu(input logic [15:0] r, input logic c, o);
    @(posedge CLK_I);
    {ALU_UPD_I, ALU_RES_I, ALU_C_I, ALU_O_I} <= {1'b1, r, c, o};
    @(posedge CLK_I);
    {ALU_UPD_I, ALU_RES_I} <= {1'b0, ~r};
    #1;
  endtask
  task automatic wr(input crf_sel_t s, input logic [31:0] d);
    @(posedge CLK_I);
    {WR_EN_I, WR_SEL_I, WR_DATA_I} <= {1'b1, s, d};
    @(posedge CLK_I);
    {WR_EN_I, WR_DATA_I} <= {1'b0, ~d};
    #1;
  endtask
  // Data shows one edge after the select is taken
  task automatic rd(input crf_sel_t s, output logic [31:0] d);
    @(posedge CLK_I);
    RD_SEL_I <= s;
    @(posedge CLK_I);
    #1;
    d = RD_DATA_O;
  endtask
  task automatic pulse(input int k, input logic [5:0] n);
    @(posedge CLK_I);
    {INSN_DONE_I, IRQ_ACK_I, SWI_I, SWI_NUM_I} <= {k == 0, k == 1, k == 2, n};
    @(posedge CLK_I);
    {INSN_DONE_I, IRQ_ACK_I, SWI_I, SWI_NUM_I} <= {3'b000, ~n};
    #1;
  endtask
  task automatic irq(input logic q, input logic [2:0] p);
    @(posedge CLK_I);
    {IRQ_REQ_I, IRQ_PRIO_I} <= {q, p};
    #1;
  endtask
endmodule

// ---- verification/crf_regfile_tb_top.sv ----
// Self-checking bench of the CPU register file
`timescale 1ns/1ps
module crf_regfile_tb_top;
  import crf_pkg::*;
  logic CLK_I = 1'b0, SYS_RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, RD_DATA_O, WR_DATA_I, rv;
  logic PREADY_O, PSLVERR_O, IRQ_ACCEPT_O, SSTEP_REQ_O, WR_EN_I, ALU_UPD_I, ALU_C_I, errv;
  logic ALU_O_I, INSN_DONE_I, IRQ_REQ_I, IRQ_ACK_I, SWI_I;
  logic [15:0] ALU_RES_I, SP_O, FLAG_O;
  logic [2:0] IRQ_PRIO_I;
  logic [5:0] SWI_NUM_I;
  logic [19:0] PC_O, VTB_O;
  crf_sel_t RD_SEL_I, WR_SEL_I;
  int error_cnt = 0, n_checks = 0;
  crf_regfile u_dut (.*);
  crf_core_model u_core (.*);
  // Clock of 10 ns
  always #5 CLK_I = ~CLK_I;
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; result left in rv and errv
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'b1, 1'b0, w, a, d};
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    @(posedge CLK_I);
    while (PREADY_O !== 1'b1) @(posedge CLK_I);
    rv = PRDATA_O;
    errv = PSLVERR_O;
    {PSEL_I, PENABLE_I, PWDATA_I} <= {2'b00, ~d};
    #1;
  endtask
  task automatic print_verdict;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bytes, pairs and core port
  task automatic t_data;
    apb(1, 8'h00, 32'h0000AAAA);
    apb(1, 8'h14, 32'h00000055);
    apb(0, 8'h00, 0);
    chk("dr0", 32'h000055AA, rv);
    apb(1, 8'h08, 32'h1111);
    apb(0, 8'h20, 0);
    chk("pair20", 32'h111155AA, rv);
    apb(1, 8'h30, 32'h22223333);
    apb(0, 8'h2C, 0);
    chk("ar1", 32'h2222, rv);
    u_core.wr(SEL_DR1, 32'h0000C3A5);
    apb(0, 8'h18, 0);
    chk("d1l", 32'hA5, rv);
    u_core.rd(SEL_P31, rv);
    chk("pair31", 32'h0000C3A5, rv);
  endtask
  // Bank flip leaves the other copy alone
  task automatic t_bank;
    apb(1, 8'h50, 32'h10);
    apb(0, 8'h00, 0);
    chk("dr0_b1", 32'h0, rv);
    apb(1, 8'h00, 32'hBBBB);
    apb(1, 8'h34, 32'h0BEE);
    apb(1, 8'h50, 32'h0);
    apb(0, 8'h00, 0);
    chk("dr0_b0", 32'h55AA, rv);
    apb(0, 8'h34, 0);
    chk("fb_b0", 32'h0, rv);
  endtask
  // Reserved bits, widths, stack select, unmapped place
  task automatic t_flags;
    apb(1, 8'h50, 32'hFFFF);
    apb(0, 8'h50, 0);
    chk("flg_rsv", 32'h70FF, rv);
    apb(1, 8'h50, 32'h0);
    apb(1, 8'h38, 32'hFFFFFFFF);
    apb(1, 8'h3C, 32'hFFFFFFFF);
    chk("pc", 32'hFFFFF, {12'h0, PC_O});
    chk("vtb", 32'hFFFFF, {12'h0, VTB_O});
    apb(1, 8'h48, 32'h1234);
    apb(1, 8'h44, 32'h5678);
    chk("sp_isp", 32'h1234, {16'h0, SP_O});
    apb(1, 8'h50, 32'h80);
    chk("sp_usp", 32'h5678, {16'h0, SP_O});
    apb(0, 8'h54, 0);
    chk("unmapped", 32'h1, {31'h0, errv});
  endtask
  // ALU flags, priority gate, acknowledge, step, software vectors
  task automatic t_core;
    u_core.alu(16'h0000, 1'b1, 1'b0);
    chk("flg_cz", 32'h0085, {16'h0, FLAG_O});
    u_core.alu(16'h8000, 1'b0, 1'b1);
    chk("flg_so", 32'h00A8, {16'h0, FLAG_O});
    apb(1, 8'h50, 32'h7040);
    u_core.irq(1'b1, 3'h7);
    chk("acc_7", 32'h0, {31'h0, IRQ_ACCEPT_O});
    apb(1, 8'h50, 32'h30C2);
    u_core.irq(1'b1, 3'h3);
    chk("acc_eq", 32'h0, {31'h0, IRQ_ACCEPT_O});
    u_core.irq(1'b1, 3'h4);
    chk("acc_gt", 32'h1, {31'h0, IRQ_ACCEPT_O});
    u_core.pulse(0, 6'h00);
    chk("step", 32'h1, {31'h0, SSTEP_REQ_O});
    u_core.pulse(1, 6'h00);
    chk("ack_flg", 32'h3000, {16'h0, FLAG_O});
    chk("ack_step", 32'h0, {31'h0, SSTEP_REQ_O});
    u_core.irq(1'b0, 3'h0);
    apb(1, 8'h50, 32'h80);
    u_core.pulse(2, 6'h1F);
    chk("swi31", 32'h0, {16'h0, FLAG_O});
    apb(1, 8'h50, 32'h80);
    u_core.pulse(2, 6'h20);
    chk("swi32", 32'h80, {16'h0, FLAG_O});
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    #1;
    chk("rst_flg", 32'h0, {16'h0, FLAG_O});
    t_data();
    t_bank();
    t_flags();
    t_core();
    print_verdict();
  end
  // Watchdog far beyond the roughly 120 cycles needed
  initial begin
    repeat (3000) @(posedge CLK_I);
    error_cnt++;
    print_verdict();
  end
endmodule
